// ==== inc/tpcb_pkg.sv ====
// shared constants, types and register map of the test pattern color bank
package tpcb_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int TPCB_ADDR_W = 8;                     // byte address width
	localparam int TPCB_DATA_W = 32;                    // bus data width
	localparam int TPCB_IDX_W  = 6;                     // register index width
	localparam int TPCB_IDX_LSB = 2;                    // byte address = index * 4

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [5:0] TPCB_IDX_COLOR0  = 6'h10;    // first color entry
	localparam logic [5:0] TPCB_IDX_COLOR1  = 6'h11;
	localparam logic [5:0] TPCB_IDX_COLOR2  = 6'h12;
	localparam logic [5:0] TPCB_IDX_COLOR3  = 6'h13;
	localparam logic [5:0] TPCB_IDX_COLOR4  = 6'h14;
	localparam logic [5:0] TPCB_IDX_COLOR5  = 6'h15;
	localparam logic [5:0] TPCB_IDX_COLOR6  = 6'h16;
	localparam logic [5:0] TPCB_IDX_COLOR7  = 6'h17;
	localparam logic [5:0] TPCB_IDX_COLOR8  = 6'h18;
	localparam logic [5:0] TPCB_IDX_COLOR9  = 6'h19;
	localparam logic [5:0] TPCB_IDX_COLOR10 = 6'h1a;
	localparam logic [5:0] TPCB_IDX_COLOR11 = 6'h1b;
	localparam logic [5:0] TPCB_IDX_COLOR12 = 6'h1c;
	localparam logic [5:0] TPCB_IDX_COLOR13 = 6'h1d;
	localparam logic [5:0] TPCB_IDX_COLOR14 = 6'h1e;
	localparam logic [5:0] TPCB_IDX_COLOR15 = 6'h1f;    // last color entry
	localparam logic [5:0] TPCB_IDX_CTRL    = 6'h20;    // pattern mode select
	localparam logic [5:0] TPCB_IDX_STATUS  = 6'h21;    // read-only state

	// ----------------------------------------------------------------
	// reset values and field layout
	// ----------------------------------------------------------------
	localparam int TPCB_NUM_COLORS = 16;                // entries in the set
	localparam logic [7:0] TPCB_COLOR8_RESET  = 8'h00;  // no value given
	localparam logic [7:0] TPCB_COLOR11_RESET = 8'h00;  // no value given
	localparam logic [15:0][7:0] TPCB_COLOR_RESET = {
		8'h00, 8'h00, 8'h00, 8'h00, TPCB_COLOR11_RESET, 8'h00, 8'h00,
		TPCB_COLOR8_RESET, 8'h80, 8'h0f, 8'hcc, 8'h55, 8'h7f, 8'hf0, 8'h33, 8'haa};
	localparam int TPCB_CTRL_MODE_LSB = 0;              // mode field position
	localparam logic [1:0] TPCB_CTRL_RESET = 2'h0;      // pattern off
	localparam logic [1:0] TPCB_MODE_OFF   = 2'h0;      // field codes
	localparam logic [1:0] TPCB_MODE_BAR   = 2'h1;
	localparam logic [1:0] TPCB_MODE_FIXED = 2'h2;
	localparam int TPCB_STAT_BYTE_LSB = 0;              // last byte sent
	localparam int TPCB_STAT_MODE_LSB = 8;              // active mode field
	localparam logic [1:0] TPCB_RESP_OKAY   = 2'h0;
	localparam logic [1:0] TPCB_RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		TPCB_OFF   = 3'b001,
		TPCB_BAR   = 3'b010,
		TPCB_FIXED = 3'b100
	} tpcb_mode_t;

	typedef struct packed {
		logic       en;                                 // one-cycle write pulse
		logic       strb;                               // low byte lane enabled
		logic [5:0] idx;                                // register index
		logic [7:0] data;                               // low byte of wdata
	} tpcb_wr_cmd_t;

	typedef struct packed {
		logic       valid;                              // byte present
		logic [7:0] data;                               // pattern byte
	} tpcb_pix_t;

endpackage

// ==== design/tpcb_color_mux.sv ====
// picks the pattern byte for the current bar or fixed-pattern position
`timescale 1ns/1ps
module tpcb_color_mux (
	input  wire logic [15:0][7:0]     colors,
	input  tpcb_pkg::tpcb_mode_t      mode,
	input  wire logic [2:0]           bar_index,
	input  wire logic [3:0]           byte_index,
	output logic [7:0]                sel_byte
);
	import tpcb_pkg::*;

	// ----------------------------------------------------------------
	// selection
	// ----------------------------------------------------------------
	// bar index is only three bits, so entries eight up never reach the
	// output in bar mode
	always_comb
	begin
		sel_byte = 8'h00;
		unique case (mode)
			TPCB_BAR:   sel_byte = colors[{1'b0, bar_index}];
			TPCB_FIXED: sel_byte = colors[byte_index];
			TPCB_OFF:   sel_byte = 8'h00;                      // idle value
		endcase
	end
endmodule // tpcb_color_mux

// ==== design/tpcb_axil_slave.sv ====
// axi4-lite slave front end: handshakes, write pulse, read capture
`timescale 1ns/1ps
module tpcb_axil_slave (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [7:0]            awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [7:0]            araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	output tpcb_pkg::tpcb_wr_cmd_t     wr_cmd,
	input  wire logic                  wr_hit,
	output logic [5:0]                 rd_idx,
	input  wire logic [31:0]           rd_data,
	input  wire logic                  rd_hit
);
	import tpcb_pkg::*;

	logic       aw_held_reg, aw_held_next;   // address waiting for data
	logic [5:0] aw_idx_reg, aw_idx_next;     // held write index
	logic       w_held_reg, w_held_next;     // data waiting for address
	logic [7:0] w_data_reg, w_data_next;     // held low byte
	logic       w_strb_reg, w_strb_next;     // held lane-0 enable
	logic       bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic       rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic       do_write;                    // both halves present

	// ----------------------------------------------------------------
	// handshakes
	// ----------------------------------------------------------------
	assign awready  = !aw_held_reg;
	assign wready   = !w_held_reg;
	assign arready  = !rvalid_reg;            // one read in flight at most
	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	assign rd_idx   = araddr[TPCB_IDX_LSB +: TPCB_IDX_W];
	assign wr_cmd   = '{en: do_write, strb: w_strb_reg, idx: aw_idx_reg, data: w_data_reg};
	assign bvalid   = bvalid_reg;
	assign bresp    = bresp_reg;
	assign rvalid   = rvalid_reg;
	assign rdata    = rdata_reg;
	assign rresp    = rresp_reg;

	// next state of both channels
	always_comb
	begin
		aw_held_next = aw_held_reg;
		aw_idx_next  = aw_idx_reg;
		w_held_next  = w_held_reg;
		w_data_next  = w_data_reg;
		w_strb_next  = w_strb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		if (awvalid && awready)
		begin
			aw_held_next = 1'b1;
			aw_idx_next  = awaddr[TPCB_IDX_LSB +: TPCB_IDX_W];
		end
		if (wvalid && wready)
		begin
			w_held_next = 1'b1;
			w_data_next = wdata[7:0];
			w_strb_next = wstrb[0];
		end
		if (bvalid_reg && bready)
			bvalid_next = 1'b0;
		// write lands on the same edge that raises bvalid
		if (do_write)
		begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_hit ? TPCB_RESP_OKAY : TPCB_RESP_SLVERR;
		end
		if (rvalid_reg && rready)
			rvalid_next = 1'b0;
		if (arvalid && arready)
		begin
			rvalid_next = 1'b1;
			rdata_next  = rd_hit ? rd_data : 32'h0000_0000;
			rresp_next  = rd_hit ? TPCB_RESP_OKAY : TPCB_RESP_SLVERR;
		end
	end

	// registers only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			aw_idx_reg  <= 6'h00;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 8'h00;
			w_strb_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= 2'h0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= 2'h0;
		end
		else
		begin
			aw_held_reg <= aw_held_next;
			aw_idx_reg  <= aw_idx_next;
			w_held_reg  <= w_held_next;
			w_data_reg  <= w_data_next;
			w_strb_reg  <= w_strb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end
endmodule // tpcb_axil_slave

// ==== design/tpcb_top.sv ====
// test pattern color bank: sixteen color bytes, mode select, pattern byte out
//
// What this block does
// - bar four sends color entry 0x14
// - bar five sends color entry 0x15
// - bar six sends color entry 0x16
// - bar seven sends color entry 0x17
// - fixed bytes five-eight from 0x14-0x17
// - fixed bytes nine-twelve from 0x18-0x1b
// - fixed bytes thirteen-sixteen from 0x1c-0x1f
// - bars zero-three send entries 0x10-0x13
// - fixed bytes one-four from 0x10-0x13
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module tpcb_top (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [7:0]            awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [7:0]            araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	input  wire logic                  pix_req,
	input  wire logic [2:0]            bar_index,
	input  wire logic [3:0]            byte_index,
	output tpcb_pkg::tpcb_pix_t        pix_out,
	output tpcb_pkg::tpcb_mode_t       mode_out
);
	import tpcb_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	tpcb_wr_cmd_t     wr_cmd;                // write pulse from the bus side
	logic             wr_hit;                // write index is mapped
	logic [5:0]       rd_idx;                // read index from the bus side
	logic [31:0]      rd_data;               // read word for that index
	logic             rd_hit;                // read index is mapped
	logic [15:0][7:0] color_reg;             // the color set
	logic [15:0][7:0] color_next;
	logic [1:0]       ctrl_mode_reg;         // mode field as written
	logic [1:0]       ctrl_mode_next;
	tpcb_mode_t       mode;                  // decoded active mode
	logic [7:0]       sel_byte;              // byte chosen for this request
	tpcb_pix_t        pix_reg;               // registered pattern output
	tpcb_pix_t        pix_next;
	logic [7:0]       last_byte_reg;         // last byte actually sent
	logic [7:0]       last_byte_next;
	logic             wr_color;              // write aimed at a color entry
	logic             rd_color;              // read aimed at a color entry

	// ----------------------------------------------------------------
	// bus front end
	// ----------------------------------------------------------------
	// the slave owns all handshakes; this module only decodes indices
	tpcb_axil_slave u_slave (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.wr_cmd  (wr_cmd),
		.wr_hit  (wr_hit),
		.rd_idx  (rd_idx),
		.rd_data (rd_data),
		.rd_hit  (rd_hit)
	);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// the color set is one contiguous run of indices, so a range test
	// covers all sixteen entries
	assign wr_color = (wr_cmd.idx >= TPCB_IDX_COLOR0) && (wr_cmd.idx <= TPCB_IDX_COLOR15);
	assign rd_color = (rd_idx >= TPCB_IDX_COLOR0) && (rd_idx <= TPCB_IDX_COLOR15);

	// status accepts writes silently; only unmapped indices error
	assign wr_hit = wr_color
		|| (wr_cmd.idx == TPCB_IDX_CTRL)
		|| (wr_cmd.idx == TPCB_IDX_STATUS);
	assign rd_hit = rd_color
		|| (rd_idx == TPCB_IDX_CTRL)
		|| (rd_idx == TPCB_IDX_STATUS);

	// ----------------------------------------------------------------
	// color set
	// ----------------------------------------------------------------
	// one entry per loop pass; every entry stays readable and writable
	// whatever the mode
	for (genvar gi = 0; gi < TPCB_NUM_COLORS; gi++)
	begin : g_color
		// next value: a lane-0 write to this entry replaces it
		always_comb
		begin
			color_next[gi] = color_reg[gi];
			if (wr_cmd.en && wr_cmd.strb && wr_color
				&& (wr_cmd.idx[3:0] == 4'(gi)))
				color_next[gi] = wr_cmd.data;
		end

		// storage; reset values differ per entry
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				color_reg[gi] <= TPCB_COLOR_RESET[gi];
			else
				color_reg[gi] <= color_next[gi];
		end
	end

	// ----------------------------------------------------------------
	// mode control
	// ----------------------------------------------------------------
	// next value of the mode field
	always_comb
	begin
		ctrl_mode_next = ctrl_mode_reg;
		if (wr_cmd.en && wr_cmd.strb && (wr_cmd.idx == TPCB_IDX_CTRL))
			ctrl_mode_next = wr_cmd.data[TPCB_CTRL_MODE_LSB +: 2];
	end

	// mode register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_mode_reg <= TPCB_CTRL_RESET;
		else
			ctrl_mode_reg <= ctrl_mode_next;
	end

	// decode; the spare code is read back as written but acts as off,
	// so a stray value can never produce a pattern
	always_comb
	begin
		case (ctrl_mode_reg)
			TPCB_MODE_BAR:   mode = TPCB_BAR;
			TPCB_MODE_FIXED: mode = TPCB_FIXED;
			default:         mode = TPCB_OFF;
		endcase
	end

	assign mode_out = mode;

	// ----------------------------------------------------------------
	// pattern byte
	// ----------------------------------------------------------------
	tpcb_color_mux u_mux (
		.colors     (color_reg),
		.mode       (mode),
		.bar_index  (bar_index),
		.byte_index (byte_index),
		.sel_byte   (sel_byte)
	);

	// one byte per request, one cycle later; a color written in the same
	// cycle as a request shows up from the following request on
	always_comb
	begin
		pix_next       = '{valid: 1'b0, data: pix_reg.data};
		last_byte_next = last_byte_reg;
		if (pix_req && (mode != TPCB_OFF))
		begin
			pix_next.valid = 1'b1;
			pix_next.data  = sel_byte;
			last_byte_next = sel_byte;
		end
	end

	// output and history registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pix_reg       <= '{valid: 1'b0, data: 8'h00};
			last_byte_reg <= 8'h00;
		end
		else
		begin
			pix_reg       <= pix_next;
			last_byte_reg <= last_byte_next;
		end
	end

	assign pix_out = pix_reg;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	// narrow registers sit in the low bits, upper bits read zero
	always_comb
	begin
		rd_data = 32'h0000_0000;
		if (rd_color)
			rd_data[7:0] = color_reg[rd_idx[3:0]];
		else if (rd_idx == TPCB_IDX_CTRL)
			rd_data[TPCB_CTRL_MODE_LSB +: 2] = ctrl_mode_reg;
		else if (rd_idx == TPCB_IDX_STATUS)
		begin
			rd_data[TPCB_STAT_BYTE_LSB +: 8] = last_byte_reg;
			rd_data[TPCB_STAT_MODE_LSB +: 3] = mode;
		end
	end
endmodule // tpcb_top

// ==== verification/tpcb_asserts.sv ====
// port-level assertion checker for the test pattern color bank
`timescale 1ns/1ps
module tpcb_asserts (
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic             awvalid,
	input wire logic             awready,
	input wire logic             wvalid,
	input wire logic             wready,
	input wire logic [1:0]       bresp,
	input wire logic             bvalid,
	input wire logic             bready,
	input wire logic [7:0]       araddr,
	input wire logic             arvalid,
	input wire logic             arready,
	input wire logic [31:0]      rdata,
	input wire logic [1:0]       rresp,
	input wire logic             rvalid,
	input wire logic             rready,
	input wire logic             pix_req,
	input tpcb_pkg::tpcb_pix_t   pix_out,
	input tpcb_pkg::tpcb_mode_t  mode_out
);
	import tpcb_pkg::*;

	// ----
	// one clock domain, so one default clocking
	// ----
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ----
	// handshake steps
	// ----
	sequence s_rd_take;
		arvalid && arready;
	endsequence
	sequence s_wr_take;
		awvalid && awready && wvalid && wready;
	endsequence

	// ----
	// pattern byte output
	// ----
	// accepted request answers next cycle
	property p_pix_answer;
		pix_req && mode_out != TPCB_OFF |=> pix_out.valid;
	endproperty
	a_pix_answer: assert property (p_pix_answer) else $error("pixel byte missing");
	// no byte without a request in an active mode
	property p_pix_cause;
		pix_out.valid |-> $past(pix_req) && $past(mode_out) != TPCB_OFF;
	endproperty
	a_pix_cause: assert property (p_pix_cause) else $error("pixel byte unrequested");
	// data holds between accepted requests
	property p_pix_hold;
		!pix_out.valid |-> $stable(pix_out.data);
	endproperty
	a_pix_hold: assert property (p_pix_hold) else $error("pixel data moved");
	property p_mode_onehot;
		$onehot(mode_out);
	endproperty
	a_mode_onehot: assert property (p_mode_onehot) else $error("mode not one-hot");

	// ----
	// register bus
	// ----
	property p_rd_answer;
		s_rd_take |=> rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	// unmapped index: error, zero data
	property p_rd_err;
		s_rd_take ##0 (araddr[7:2] < 6'h10 || araddr[7:2] > 6'h21)
			|=> rresp == TPCB_RESP_SLVERR && rdata == 32'h0;
	endproperty
	a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
	property p_rd_ok;
		s_rd_take ##0 (araddr[7:2] >= 6'h10 && araddr[7:2] <= 6'h21)
			|=> rresp == TPCB_RESP_OKAY;
	endproperty
	a_rd_ok: assert property (p_rd_ok) else $error("mapped read refused");
	property p_rd_hold;
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
	property p_ar_block;
		rvalid |-> !arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("address taken while busy");
	property p_wr_answer;
		s_wr_take |=> ##[0:2] bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	property p_wr_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");

	// ----
	// coverage of a fixed-mode request
	// ----
	c_pix: cover property (pix_req && mode_out == TPCB_FIXED);
endmodule // tpcb_asserts

bind tpcb_top tpcb_asserts u_asserts (.aclk, .aresetn, .awvalid, .awready, .wvalid,
	.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
	.rvalid, .rready, .pix_req, .pix_out, .mode_out);

// ==== verification/tpcb_bench.sv ====
// self-checking bench: register access and pattern bytes of the color bank
`timescale 1ns/1ps
module tpcb_bench;
	import tpcb_pkg::*;

	// ----
	// port signals and bench state
	// ----
	logic                 aclk, aresetn;
	logic [7:0]           awaddr, araddr;
	logic                 awvalid, awready, wvalid, wready, bvalid, bready;
	logic                 arvalid, arready, rvalid, rready, pix_req;
	logic [31:0]          wdata, rdata;
	logic [3:0]           wstrb, byte_index;
	logic [1:0]           bresp, rresp;
	logic [2:0]           bar_index;
	tpcb_pix_t            pix_out;
	tpcb_mode_t           mode_out;
	int                   n_errors, n_checks, cyc, i;
	logic [7:0]           col [16];       // expected color set
	logic [7:0]           rst_tab [16] = '{8'haa, 8'h33, 8'hf0, 8'h7f, 8'h55, 8'hcc,
		8'h0f, 8'h80, TPCB_COLOR8_RESET, 8'h00, 8'h00, TPCB_COLOR11_RESET,
		8'h00, 8'h00, 8'h00, 8'h00};

	tpcb_top DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .pix_req, .bar_index, .byte_index,
		.pix_out, .mode_out);

	// ----
	// clock and hang guard
	// ----
	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// ceiling well above the few hundred cycles the run needs
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			results();
		end
	end

	// ----
	// compare and report
	// ----
	task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %0t data got %h want %h", $time, g, e);
		end
	endtask
	task automatic cmp_flag(input logic [1:0] g, input logic [1:0] e);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %0t flag got %h want %h", $time, g, e);
		end
	endtask
	task automatic results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// byte address of color entry n
	function automatic logic [7:0] ca(input int n);
		return {6'(TPCB_IDX_COLOR0 + n), 2'b00};
	endfunction

	// ----
	// bus tasks: sample mid-cycle, act just after the edge
	// ----
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		logic ta, tw, tb, done;
		logic [1:0] r;
		done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done)
		begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			r = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (tb)
			begin
				bready <= 1'b0;
				done = 1'b1;
			end
		end
		cmp_flag(r, er);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ta, tr, done;
		logic [31:0] d;
		logic [1:0] r;
		done = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done)
		begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta)
				arvalid <= 1'b0;
			if (tr)
			begin
				rready <= 1'b0;
				done = 1'b1;
			end
		end
		cmp_data(d, e);
		cmp_flag(r, er);
	endtask
	// one request pulse, answer looked at in the following cycle
	task automatic pix(input logic [2:0] b, input logic [3:0] y, input logic v,
		input logic [7:0] e);
		@(posedge aclk);
		pix_req <= 1'b1;
		bar_index <= b;
		byte_index <= y;
		@(posedge aclk);
		pix_req <= 1'b0;
		@(negedge aclk);
		cmp_flag({1'b0, pix_out.valid}, {1'b0, v});
		cmp_data({24'h0, pix_out.data}, {24'h0, e});
	endtask

	// ----
	// main sequence
	// ----
	initial
	begin
		aresetn <= 1'b0;
		awaddr <= 8'h00;
		awvalid <= 1'b0;
		wdata <= 32'h0;
		wstrb <= 4'h0;
		wvalid <= 1'b0;
		bready <= 1'b0;
		araddr <= 8'h00;
		arvalid <= 1'b0;
		rready <= 1'b0;
		pix_req <= 1'b0;
		bar_index <= 3'h0;
		byte_index <= 4'h0;
		col = rst_tab;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values, mode off
		for (i = 0; i < 16; i++)
			axi_rd(ca(i), {24'h0, col[i]}, TPCB_RESP_OKAY);
		axi_rd(8'h80, 32'h0, TPCB_RESP_OKAY);
		axi_rd(8'h84, 32'h100, TPCB_RESP_OKAY);
		// unmapped places are refused
		axi_rd(8'h3c, 32'h0, TPCB_RESP_SLVERR);
		axi_wr(8'h88, 32'hff, 4'hf, TPCB_RESP_SLVERR);
		axi_rd(8'h88, 32'h0, TPCB_RESP_SLVERR);
		// distinct values, upper bytes dropped
		for (i = 0; i < 16; i++)
		begin
			col[i] = 8'(i * 8'h11) ^ 8'h5a;
			axi_wr(ca(i), {24'ha5a5a5, col[i]}, 4'hf, TPCB_RESP_OKAY);
		end
		for (i = 0; i < 16; i++)
			axi_rd(ca(i), {24'h0, col[i]}, TPCB_RESP_OKAY);
		// low lane off leaves the entry alone
		axi_wr(ca(4), 32'hff, 4'he, TPCB_RESP_OKAY);
		axi_rd(ca(4), {24'h0, col[4]}, TPCB_RESP_OKAY);
		// status ignores writes
		axi_wr(8'h84, 32'hffffffff, 4'hf, TPCB_RESP_OKAY);
		axi_rd(8'h84, 32'h100, TPCB_RESP_OKAY);
		// bar mode, byte index aimed at the upper entries
		axi_wr(8'h80, 32'h1, 4'hf, TPCB_RESP_OKAY);
		cmp_data({29'h0, mode_out}, {29'h0, TPCB_BAR});
		for (i = 0; i < 8; i++)
			pix(3'(i), 4'(15 - i), 1'b1, col[i]);
		axi_rd(8'h84, {21'h0, 3'b010, col[7]}, TPCB_RESP_OKAY);
		// fixed mode, bar index aimed elsewhere
		axi_wr(8'h80, 32'h2, 4'hf, TPCB_RESP_OKAY);
		for (i = 0; i < 16; i++)
			pix(3'(7 - i), 4'(i), 1'b1, col[i]);
		// spare code and off: no byte, data holds
		axi_wr(8'h80, 32'h3, 4'hf, TPCB_RESP_OKAY);
		axi_rd(8'h80, 32'h3, TPCB_RESP_OKAY);
		cmp_data({29'h0, mode_out}, {29'h0, TPCB_OFF});
		pix(3'h0, 4'h0, 1'b0, col[15]);
		axi_wr(8'h80, 32'h0, 4'hf, TPCB_RESP_OKAY);
		pix(3'h1, 4'h1, 1'b0, col[15]);
		// second reset in mid run
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(ca(4), 32'h55, TPCB_RESP_OKAY);
		axi_rd(8'h80, 32'h0, TPCB_RESP_OKAY);
		results();
	end
endmodule // tpcb_bench
